// ===== rtl/oc_rec_consts.svh
// constants shared by the overcurrent event recorder files
`ifndef OC_REC_CONSTS_SVH
`define OC_REC_CONSTS_SVH

// ----------------------------------------------------------------
// structure
// ----------------------------------------------------------------
`define NUM_STAGES   4
`define STAGE_W      2
`define NUM_COND     6
`define COND_W       3
`define NUM_REC_COND 3
`define REC_EVT_W    2
`define MEM_DEPTH    48
`define MEM_AW       6
`define SLOT_W       4
`define LOG_DEPTH    4'hC
`define SLOT_LAST    4'hB

// ----------------------------------------------------------------
// condition indices within a stage
// ----------------------------------------------------------------
`define COND_START    0
`define COND_TRIP     1
`define COND_BLOCK    2
`define COND_NOVOLT   3
`define COND_LIVEANG  4
`define COND_VOLTMEM  5

// ----------------------------------------------------------------
// store selection bits and data widths
// ----------------------------------------------------------------
`define SEL_ON   0
`define SEL_OFF  1
`define TS_W     32
`define CNT_W    16
`define CNT_MAX  16'hFFFF
`define VAL_W    16
`define FTYPE_W  4
`define GRP_W    3
`define CODE_W   4

`endif

// ===== rtl/oc_rec_pkg.sv
// types shared by the overcurrent event recorder files
package oc_rec_pkg;
`include "oc_rec_consts.svh"

  typedef logic [`MEM_AW-1:0] mem_addr_t;

  typedef struct packed {
    logic [`TS_W-1:0]      ts_ms;
    logic [`REC_EVT_W-1:0] evt;
    logic [`FTYPE_W-1:0]   fault_type;
    logic [`VAL_W-1:0]     pre_trig_cur;
    logic [`VAL_W-1:0]     fault_cur;
    logic [`VAL_W-1:0]     pre_fault_avg;
    logic [`VAL_W-1:0]     trip_remain;
    logic [`GRP_W-1:0]     set_group;
    logic [`VAL_W-1:0]     op_angle;
  } fault_rec_t;

endpackage

// ===== rtl/rec_mem_if.sv
// port bundle between the recorder control and its record memory
`timescale 1ns/10ps
interface rec_mem_if;
  logic                   wr_en;
  oc_rec_pkg::mem_addr_t  wr_addr;
  oc_rec_pkg::fault_rec_t wr_data;
  logic                   rd_en;
  oc_rec_pkg::mem_addr_t  rd_addr;
  oc_rec_pkg::fault_rec_t rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_en, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data,
                input rd_en, input rd_addr, output rd_data);
endinterface

// ===== rtl/fault_rec_mem.sv
// fault record storage for all stages, registered read port
`timescale 1ns/10ps
`include "oc_rec_consts.svh"
module fault_rec_mem (
  input  logic sys_clk,    // system clock
  input  logic sys_rst,    // synchronous reset, active high
  rec_mem_if.mem bus       // write and read port
);
  oc_rec_pkg::fault_rec_t store [`MEM_DEPTH];
  oc_rec_pkg::fault_rec_t rd_data_r;

  // record contents need no reset, only the read register does
  always_ff @(posedge sys_clk) begin
    if (bus.wr_en) begin
      store[bus.wr_addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_data_r <= '0;
    end else if (bus.rd_en) begin
      rd_data_r <= store[bus.rd_addr];
    end
  end

  assign bus.rd_data = rd_data_r;
endmodule

// ===== rtl/overcurrent_event_recorder.sv
// event messages, counters and fault record log of four directional overcurrent stages
`timescale 1ns/10ps
`include "oc_rec_consts.svh"
module overcurrent_event_recorder (
  input  logic                                             sys_clk,          // system clock
  input  logic                                             sys_rst,          // sync reset
  input  logic [`TS_W-1:0]                                 ts_ms,            // ms time
  input  logic [`NUM_STAGES-1:0][`NUM_COND-1:0]            stage_status,     // stage signals
  input  logic [`NUM_STAGES-1:0][`NUM_COND-1:0][1:0]       store_sel,        // on/off select
  input  logic [`NUM_STAGES-1:0][`FTYPE_W-1:0]             proc_fault_type,  // fault type
  input  logic [`NUM_STAGES-1:0][`VAL_W-1:0]               proc_pre_trig,    // -20ms current
  input  logic [`NUM_STAGES-1:0][`VAL_W-1:0]               proc_fault_cur,   // fault current
  input  logic [`NUM_STAGES-1:0][`VAL_W-1:0]               proc_pre_avg,     // -200ms average
  input  logic [`NUM_STAGES-1:0][`VAL_W-1:0]               proc_trip_remain, // ms to trip
  input  logic [`NUM_STAGES-1:0][`GRP_W-1:0]               proc_set_group,   // active group
  input  logic [`NUM_STAGES-1:0][`VAL_W-1:0]               proc_op_angle,    // angle
  input  logic [`NUM_STAGES-1:0]                           cnt_clr,          // counter clear
  output logic                                             evt_valid,        // message valid
  input  logic                                             evt_ready,        // buffer ready
  output logic [`STAGE_W-1:0]                              evt_stage,        // message stage
  output logic [`CODE_W-1:0]                               evt_code,         // {cond, off}
  output logic [`TS_W-1:0]                                 evt_time,         // message time
  output logic [`NUM_STAGES-1:0][`CNT_W-1:0]               cnt_start,        // start count
  output logic [`NUM_STAGES-1:0][`CNT_W-1:0]               cnt_trip,         // trip count
  output logic [`NUM_STAGES-1:0][`CNT_W-1:0]               cnt_block,        // blocked count
  output logic [`NUM_STAGES-1:0][`SLOT_W-1:0]              rec_count,        // entries held
  input  logic                                             rec_rd_req,       // read request
  input  logic [`STAGE_W-1:0]                              rec_rd_stage,     // read stage
  input  logic [`SLOT_W-1:0]                               rec_rd_idx,       // 0 = oldest
  output logic                                             rec_rd_valid,     // read answer
  output logic                                             rec_rd_hit,       // idx in range
  output oc_rec_pkg::fault_rec_t                           rec_rd_data       // record read
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [`SLOT_W-1:0] wrap_add(input logic [`SLOT_W-1:0] a,
                                                  input logic [`SLOT_W-1:0] b);
    logic [`SLOT_W:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    if (sum >= {1'b0, `LOG_DEPTH}) begin
      sum = sum - {1'b0, `LOG_DEPTH};
    end
    return sum[`SLOT_W-1:0];
  endfunction

  function automatic oc_rec_pkg::mem_addr_t mem_addr(input logic [`STAGE_W-1:0] s,
                                                     input logic [`SLOT_W-1:0]  slot);
    return oc_rec_pkg::mem_addr_t'(s) * oc_rec_pkg::mem_addr_t'(`LOG_DEPTH)
           + oc_rec_pkg::mem_addr_t'(slot);
  endfunction

  function automatic logic [`CNT_W-1:0] cnt_next(input logic [`CNT_W-1:0] v,
                                                 input logic              clr,
                                                 input logic              inc);
    logic [`CNT_W-1:0] base;
    base = clr ? '0 : v;
    if (inc && base != `CNT_MAX) begin
      base = base + 1'b1;
    end
    return base;
  endfunction

  // ----------------------------------------------------------------
  // change detection
  // ----------------------------------------------------------------
  logic [`NUM_STAGES-1:0][`NUM_COND-1:0] status_prev_r;
  logic [`NUM_STAGES-1:0][`NUM_COND-1:0] chg;
  logic [`NUM_STAGES-1:0][`NUM_COND-1:0] rise;
  logic [`NUM_STAGES-1:0][`NUM_COND-1:0] want;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status_prev_r <= '0;
    end else begin
      status_prev_r <= stage_status;
    end
  end

  always_comb begin
    chg  = stage_status ^ status_prev_r;
    rise = chg & stage_status;
    for (int s = 0; s < `NUM_STAGES; s++) begin
      for (int c = 0; c < `NUM_COND; c++) begin
        want[s][c] = chg[s][c] && (stage_status[s][c] ? store_sel[s][c][`SEL_ON]
                                                        : store_sel[s][c][`SEL_OFF]);
      end
    end
  end

  // ----------------------------------------------------------------
  // pending messages and output stage
  // ----------------------------------------------------------------
  logic [`NUM_STAGES-1:0][`NUM_COND-1:0]           pend_r;
  logic [`NUM_STAGES-1:0][`NUM_COND-1:0]           pend_off_r;
  logic [`NUM_STAGES-1:0][`NUM_COND-1:0][`TS_W-1:0] pend_ts_r;
  logic                                            pick_found;
  logic [`STAGE_W-1:0]                             pick_s;
  logic [`COND_W-1:0]                              pick_c;
  logic                                            take;
  logic                                            evt_valid_r;
  logic [`STAGE_W-1:0]                             evt_stage_r;
  logic [`CODE_W-1:0]                              evt_code_r;
  logic [`TS_W-1:0]                                evt_time_r;

  // lowest stage and condition first; a second change of one condition
  // before its message leaves replaces the waiting one
  always_comb begin
    pick_found = 1'b0;
    pick_s     = '0;
    pick_c     = '0;
    for (int s = `NUM_STAGES - 1; s >= 0; s--) begin
      for (int c = `NUM_COND - 1; c >= 0; c--) begin
        if (pend_r[s][c]) begin
          pick_found = 1'b1;
          pick_s     = `STAGE_W'(s);
          pick_c     = `COND_W'(c);
        end
      end
    end
  end

  assign take = pick_found && (!evt_valid_r || evt_ready);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_r     <= '0;
      pend_off_r <= '0;
      pend_ts_r  <= '0;
    end else begin
      for (int s = 0; s < `NUM_STAGES; s++) begin
        for (int c = 0; c < `NUM_COND; c++) begin
          if (take && pick_s == `STAGE_W'(s) && pick_c == `COND_W'(c)) begin
            pend_r[s][c] <= 1'b0;
          end
          // new change wins over the hand-off in the same cycle
          if (want[s][c]) begin
            pend_r[s][c]     <= 1'b1;
            pend_off_r[s][c] <= ~stage_status[s][c];
            pend_ts_r[s][c]  <= ts_ms;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      evt_valid_r <= 1'b0;
      evt_stage_r <= '0;
      evt_code_r  <= '0;
      evt_time_r  <= '0;
    end else if (!evt_valid_r || evt_ready) begin
      evt_valid_r <= pick_found;
      if (pick_found) begin
        evt_stage_r <= pick_s;
        evt_code_r  <= {pick_c, pend_off_r[pick_s][pick_c]};
        evt_time_r  <= pend_ts_r[pick_s][pick_c];
      end
    end
  end

  assign evt_valid = evt_valid_r;
  assign evt_stage = evt_stage_r;
  assign evt_code  = evt_code_r;
  assign evt_time  = evt_time_r;

  // ----------------------------------------------------------------
  // cumulative counters
  // ----------------------------------------------------------------
  logic [`NUM_STAGES-1:0][`CNT_W-1:0] cnt_start_r;
  logic [`NUM_STAGES-1:0][`CNT_W-1:0] cnt_trip_r;
  logic [`NUM_STAGES-1:0][`CNT_W-1:0] cnt_block_r;

  // counters saturate; an event in the clearing cycle still counts
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_start_r <= '0;
      cnt_trip_r  <= '0;
      cnt_block_r <= '0;
    end else begin
      for (int s = 0; s < `NUM_STAGES; s++) begin
        cnt_start_r[s] <= cnt_next(cnt_start_r[s], cnt_clr[s], rise[s][`COND_START]);
        cnt_trip_r[s]  <= cnt_next(cnt_trip_r[s], cnt_clr[s], rise[s][`COND_TRIP]);
        cnt_block_r[s] <= cnt_next(cnt_block_r[s], cnt_clr[s], rise[s][`COND_BLOCK]);
      end
    end
  end

  assign cnt_start = cnt_start_r;
  assign cnt_trip  = cnt_trip_r;
  assign cnt_block = cnt_block_r;

  // ----------------------------------------------------------------
  // fault record log
  // ----------------------------------------------------------------
  rec_mem_if mbus ();

  logic [`NUM_STAGES-1:0][`NUM_REC_COND-1:0]            rec_pend_r;
  logic [`NUM_STAGES-1:0][`NUM_REC_COND-1:0][`TS_W-1:0] rec_ts_r;
  logic [`NUM_STAGES-1:0][`SLOT_W-1:0]                  wptr_r;
  logic [`NUM_STAGES-1:0][`SLOT_W-1:0]                  count_r;
  logic                                                 rec_found;
  logic [`STAGE_W-1:0]                                  rec_s;
  logic [`REC_EVT_W-1:0]                                rec_k;
  logic [`SLOT_W-1:0]                                   rd_slot;
  logic                                                 rec_rd_valid_r;
  logic                                                 rec_rd_hit_r;

  always_comb begin
    rec_found = 1'b0;
    rec_s     = '0;
    rec_k     = '0;
    for (int s = `NUM_STAGES - 1; s >= 0; s--) begin
      for (int k = `NUM_REC_COND - 1; k >= 0; k--) begin
        if (rec_pend_r[s][k]) begin
          rec_found = 1'b1;
          rec_s     = `STAGE_W'(s);
          rec_k     = `REC_EVT_W'(k);
        end
      end
    end
  end

  // only ON edges of start, trip and blocked are logged
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rec_pend_r <= '0;
      rec_ts_r   <= '0;
    end else begin
      for (int s = 0; s < `NUM_STAGES; s++) begin
        for (int k = 0; k < `NUM_REC_COND; k++) begin
          if (rec_found && rec_s == `STAGE_W'(s) && rec_k == `REC_EVT_W'(k)) begin
            rec_pend_r[s][k] <= 1'b0;
          end
          if (rise[s][k]) begin
            rec_pend_r[s][k] <= 1'b1;
            rec_ts_r[s][k]   <= ts_ms;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wptr_r  <= '0;
      count_r <= '0;
    end else if (rec_found) begin
      wptr_r[rec_s] <= wrap_add(wptr_r[rec_s], `SLOT_W'(1));
      if (count_r[rec_s] != `LOG_DEPTH) begin
        count_r[rec_s] <= count_r[rec_s] + 1'b1;
      end
    end
  end

  // process data are those present when the record is written
  assign mbus.wr_en                 = rec_found;
  assign mbus.wr_addr               = mem_addr(rec_s, wptr_r[rec_s]);
  assign mbus.wr_data.ts_ms         = rec_ts_r[rec_s][rec_k];
  assign mbus.wr_data.evt           = rec_k;
  assign mbus.wr_data.fault_type    = proc_fault_type[rec_s];
  assign mbus.wr_data.pre_trig_cur  = proc_pre_trig[rec_s];
  assign mbus.wr_data.fault_cur     = proc_fault_cur[rec_s];
  assign mbus.wr_data.pre_fault_avg = proc_pre_avg[rec_s];
  assign mbus.wr_data.trip_remain   = proc_trip_remain[rec_s];
  assign mbus.wr_data.set_group     = proc_set_group[rec_s];
  assign mbus.wr_data.op_angle      = proc_op_angle[rec_s];

  // index 0 is the oldest entry once the log has wrapped
  assign rd_slot = (count_r[rec_rd_stage] == `LOG_DEPTH)
                   ? wrap_add(wptr_r[rec_rd_stage], rec_rd_idx) : rec_rd_idx;
  assign mbus.rd_en   = rec_rd_req;
  assign mbus.rd_addr = mem_addr(rec_rd_stage, rd_slot);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rec_rd_valid_r <= 1'b0;
      rec_rd_hit_r   <= 1'b0;
    end else begin
      rec_rd_valid_r <= rec_rd_req;
      rec_rd_hit_r   <= rec_rd_req && (rec_rd_idx < count_r[rec_rd_stage]);
    end
  end

  fault_rec_mem u_mem (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .bus     (mbus.mem)
  );

  assign rec_rd_valid = rec_rd_valid_r;
  assign rec_rd_hit   = rec_rd_hit_r;
  assign rec_rd_data  = mbus.rd_data;
  assign rec_count    = count_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_evt_hold;
    evt_valid && !evt_ready |=> evt_valid && $stable(evt_code) && $stable(evt_time);
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("message changed while stalled");

  property p_on_pend;
    $rose(stage_status[0][`COND_START]) && store_sel[0][`COND_START][`SEL_ON]
      |=> pend_r[0][`COND_START] && !pend_off_r[0][`COND_START];
  endproperty
  a_on_pend: assert property (p_on_pend) else $error("selected ON change not queued");

  property p_off_filtered;
    $fell(stage_status[1][`COND_TRIP]) && !store_sel[1][`COND_TRIP][`SEL_OFF]
      && !pend_r[1][`COND_TRIP] |=> !pend_r[1][`COND_TRIP];
  endproperty
  a_off_filtered: assert property (p_off_filtered) else $error("unselected OFF queued");

  property p_ts;
    $rose(stage_status[3][`COND_LIVEANG]) && store_sel[3][`COND_LIVEANG][`SEL_ON]
      |=> pend_ts_r[3][`COND_LIVEANG] == $past(ts_ms);
  endproperty
  a_ts: assert property (p_ts) else $error("time stamp not from change cycle");

  property p_code_range;
    evt_valid |-> evt_code[`CODE_W-1:1] < `COND_W'(`NUM_COND);
  endproperty
  a_code_range: assert property (p_code_range) else $error("event code out of range");

  property p_cnt_clr;
    cnt_clr[0] && !rise[0][`COND_START] |=> cnt_start[0] == '0;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("start counter not cleared");

  property p_cnt_inc;
    !cnt_clr[1] && rise[1][`COND_TRIP] && cnt_trip[1] != `CNT_MAX
      |=> cnt_trip[1] == $past(cnt_trip[1]) + 1'b1;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("trip counter missed an event");

  property p_count_max;
    rec_count[3] <= `LOG_DEPTH;
  endproperty
  a_count_max: assert property (p_count_max) else $error("log count above twelve");

  property p_rec_on;
    $rose(stage_status[0][`COND_BLOCK]) |=> rec_pend_r[0][`COND_BLOCK] ##[0:12] mbus.wr_en;
  endproperty
  a_rec_on: assert property (p_rec_on) else $error("blocked ON not recorded");

  property p_wrap;
    mbus.wr_en && rec_s == 2'h1 && wptr_r[1] == `SLOT_LAST |=> wptr_r[1] == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("write pointer did not wrap");

  c_evt_stall: cover property (evt_valid && !evt_ready ##1 evt_valid && evt_ready);
  c_log_full:  cover property (rec_count[1] == `LOG_DEPTH && mbus.wr_en && rec_s == 2'h1);
  c_cnt_both:  cover property (cnt_clr[2] && rise[2][`COND_START]);
  c_rd_hit:    cover property (rec_rd_valid && rec_rd_hit);
endmodule

// ===== test/evt_sink.sv
// model of the main event buffer taking event messages with stalls
`timescale 1ns/10ps
module evt_sink (
  input  wire logic        sys_clk,   // system clock
  input  wire logic        sys_rst,   // sync reset
  input  wire logic        evt_valid, // message valid
  input  wire logic [1:0]  evt_stage, // message stage
  input  wire logic [3:0]  evt_code,  // message code
  input  wire logic [31:0] evt_time,  // message time
  output logic             evt_ready  // buffer accepts
);
  logic [37:0] q[$];
  logic [1:0]  ph_r = 2'h0;
  initial evt_ready = 1'b0;
  // stall one cycle in three so held messages get exercised
  always @(posedge sys_clk) begin
    if (!sys_rst && evt_valid && evt_ready) begin
      q.push_back({evt_stage, evt_code, evt_time});
    end
    ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
    evt_ready <= #1 (ph_r != 2'h2);
  end
endmodule

// ===== test/overcurrent_event_recorder_test.sv
// self-checking bench for the overcurrent event recorder
`timescale 1ns/10ps
module overcurrent_event_recorder_test;
  logic                   sys_clk, sys_rst, evt_valid, evt_ready, rec_rd_req;
  logic                   rec_rd_valid, rec_rd_hit;
  logic [31:0]            ts_ms = 32'h0;
  logic [31:0]            evt_time;
  logic [3:0][5:0]        stage_status;
  logic [3:0][5:0][1:0]   store_sel;
  logic [3:0][3:0]        proc_fault_type, rec_count;
  logic [3:0][2:0]        proc_set_group;
  logic [3:0][15:0]       proc_pre_trig, proc_fault_cur, proc_pre_avg;
  logic [3:0][15:0]       proc_trip_remain, proc_op_angle;
  logic [3:0][15:0]       cnt_start, cnt_trip, cnt_block;
  logic [3:0]             cnt_clr, evt_code, rec_rd_idx;
  logic [1:0]             evt_stage, rec_rd_stage;
  oc_rec_pkg::fault_rec_t rec_rd_data;
  int                     bad_count = 0;
  int                     n_compared = 0;

  overcurrent_event_recorder u_dut (.sys_clk, .sys_rst, .ts_ms, .stage_status, .store_sel,
    .proc_fault_type, .proc_pre_trig, .proc_fault_cur, .proc_pre_avg, .proc_trip_remain,
    .proc_set_group, .proc_op_angle, .cnt_clr, .evt_valid, .evt_ready, .evt_stage,
    .evt_code, .evt_time, .cnt_start, .cnt_trip, .cnt_block, .rec_count, .rec_rd_req,
    .rec_rd_stage, .rec_rd_idx, .rec_rd_valid, .rec_rd_hit, .rec_rd_data);
  evt_sink u_sink (.sys_clk, .sys_rst, .evt_valid, .evt_stage, .evt_code, .evt_time,
    .evt_ready);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // distinct time each cycle so a stamp from the wrong cycle shows
  always @(posedge sys_clk) ts_ms <= ts_ms + 32'h1;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic stop_test();
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [37:0] exp, logic [37:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  task automatic set_cond(int st, int c, logic v, output logic [31:0] t);
    stage_status[st][c] = v;
    t = ts_ms;
    tick(4);
  endtask
  task automatic get_msg(logic [37:0] exp);
    int i;
    for (i = 0; i < 100 && u_sink.q.size() == 0; i++) tick();
    if (u_sink.q.size() == 0) begin
      bad_count++;
      $display("ERROR message expected %0h seen none", exp);
      stop_test();
    end else begin
      chk("message", exp, u_sink.q.pop_front());
    end
  endtask
  task automatic rd(int st, int ix);
    // let an edge pass so a back-to-back call never re-raises the request at once
    tick();
    rec_rd_stage = 2'(st);
    rec_rd_idx = 4'(ix);
    rec_rd_req = 1'b1;
    tick();
    rec_rd_req = 1'b0;
    chk("read valid", 1, rec_rd_valid);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_onoff();
    logic [31:0] t;
    store_sel[0][0] = 2'h3;
    set_cond(0, 0, 1'b1, t);
    get_msg({2'h0, 4'h0, t});
    set_cond(0, 0, 1'b0, t);
    get_msg({2'h0, 4'h1, t});
  endtask
  task automatic t_select();
    logic [31:0] t, t2;
    store_sel[2][1] = 2'h1;
    set_cond(2, 1, 1'b1, t);
    set_cond(2, 1, 1'b0, t2);
    get_msg({2'h2, 4'h2, t});
    store_sel[2][1] = 2'h2;
    set_cond(2, 1, 1'b1, t);
    set_cond(2, 1, 1'b0, t2);
    get_msg({2'h2, 4'h3, t2});
    tick(10);
    chk("dropped messages", 0, u_sink.q.size());
  endtask
  task automatic t_codes();
    logic [31:0] t;
    store_sel[3] = {6{2'h3}};
    for (int c = 0; c < 6; c++) begin
      set_cond(3, c, 1'b1, t);
      get_msg({2'h3, 4'(c * 2), t});
      set_cond(3, c, 1'b0, t);
      get_msg({2'h3, 4'(c * 2 + 1), t});
    end
    chk("stage 3 entries", 3, rec_count[3]);
    chk("stage 2 entries", 2, rec_count[2]);
  endtask
  task automatic t_count();
    logic [31:0] t;
    cnt_clr[0] = 1'b1;
    tick();
    cnt_clr[0] = 1'b0;
    tick();
    chk("start count clear", 0, cnt_start[0]);
    repeat (2) begin
      set_cond(0, 0, 1'b1, t);
      set_cond(0, 0, 1'b0, t);
    end
    set_cond(0, 2, 1'b1, t);
    set_cond(0, 2, 1'b0, t);
    chk("start count", 2, cnt_start[0]);
    chk("block count", 1, cnt_block[0]);
    chk("trip count", 0, cnt_trip[0]);
    chk("other stage count", 1, cnt_start[3]);
    cnt_clr[0] = 1'b1;
    tick();
    cnt_clr[0] = 1'b0;
    chk("start count cleared", 0, cnt_start[0]);
    tick(10);
    u_sink.q.delete();
  endtask
  task automatic t_log();
    logic [31:0] ts [13];
    logic [31:0] x;
    for (int i = 0; i < 13; i++) begin
      proc_fault_type[1] = 4'(i);
      proc_pre_trig[1] = 16'h0300 + 16'(i);
      proc_fault_cur[1] = 16'h0100 + 16'(i);
      proc_pre_avg[1] = 16'h0400 + 16'(i);
      proc_trip_remain[1] = 16'h0500 + 16'(i);
      proc_set_group[1] = 3'(i);
      proc_op_angle[1] = 16'h0200 + 16'(i);
      set_cond(1, 1, 1'b1, ts[i]);
      set_cond(1, 4, 1'b1, x);
      set_cond(1, 1, 1'b0, x);
      set_cond(1, 4, 1'b0, x);
    end
    chk("stage 1 entries", 12, rec_count[1]);
    rd(1, 0);
    chk("oldest hit", 1, rec_rd_hit);
    chk("oldest time", ts[1], rec_rd_data.ts_ms);
    chk("oldest event", 1, rec_rd_data.evt);
    chk("oldest current", 16'h0101, rec_rd_data.fault_cur);
    chk("oldest group", 1, rec_rd_data.set_group);
    chk("oldest angle", 16'h0201, rec_rd_data.op_angle);
    chk("oldest remain", 16'h0501, rec_rd_data.trip_remain);
    chk("oldest fault type", 1, rec_rd_data.fault_type);
    chk("oldest pre-trigger", 16'h0301, rec_rd_data.pre_trig_cur);
    chk("oldest average", 16'h0401, rec_rd_data.pre_fault_avg);
    rd(1, 11);
    chk("newest time", ts[12], rec_rd_data.ts_ms);
    rd(1, 12);
    chk("beyond hit", 0, rec_rd_hit);
  endtask

  initial begin
    sys_rst = 1'b1;
    {stage_status, store_sel, cnt_clr, rec_rd_req, rec_rd_stage, rec_rd_idx} = '0;
    {proc_fault_type, proc_pre_trig, proc_fault_cur, proc_pre_avg} = '0;
    {proc_trip_remain, proc_set_group, proc_op_angle} = '0;
    tick(20);
    sys_rst = 1'b0;
    tick();
    chk("reset valid", 0, evt_valid);
    chk("reset entries", 0, rec_count);
    t_onoff();
    t_select();
    t_codes();
    t_count();
    t_log();
    stop_test();
  end
endmodule
